// >>> design/host_slave_port.sv
/*
 * parallel host slave port with port e pin logic and apb registers.
 * assumes an apb master on pclk, and a host whose strobes and data
 * pins are asynchronous to pclk.
 */
module host_slave_port
   import host_port_pkg::*;
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // data port pins
   input wire logic [7:0] data_port_in,
   output logic [7:0] data_port_out,
   output logic data_port_oe,
   // port e pins 0 to 2
   input wire logic [2:0] port_e_in,
   output logic [2:0] port_e_out,
   output logic [2:0] port_e_oe,
   // port e pin 3 and its high-voltage detector
   input wire logic port_e_pin3,
   input wire logic high_voltage_in,
   output logic prog_entry_detect,
   output logic external_reset_req,
   // device context
   input wire logic ext_reset_pin_enable,
   input wire logic pwm_multi_out_active,
   output logic [2:0] analog_pin_sel
);

   // ------------------------------------------------------------
   // declarations
   // ------------------------------------------------------------
   logic [2:0] pin_s, dir_q, out_lat_q, analog_en;
   logic [5:0] acfg_q;
   logic [7:0] in_buf_q, out_buf_q;
   logic mode_q, in_full_q, out_full_q, overrun_q, irq_q;
   logic [31:0] prdata_q;
   logic slverr_q, pin3_q, hv_q, ext_rst_q;
   host_state_type state_q, state_d;
   logic host_active, wr_low, rd_low, wr_end, rd_start, rd_end;
   logic setup, access, hit_known;
   logic sw_wr_data, sw_rd_data, sw_wr_dir, sw_wr_stat;

   // ------------------------------------------------------------
   // strobe synchronisers, idle high
   // ------------------------------------------------------------
   // host strobes are asynchronous, so only the assertions see them raw
   sync_bank #(.W(3), .RST_VAL(3'h7)) u_strobe_sync
   (
      .pclk(pclk),
      .presetn(presetn),
      .d(port_e_in),
      .q(pin_s)
   );

   // ------------------------------------------------------------
   // pin configuration
   // ------------------------------------------------------------
   // analog while config below the digital window
   assign analog_en = (acfg_q[3:0] < PCFG_DIGITAL_MIN) ? 3'h7 : 3'h0;
   assign analog_pin_sel = analog_en;

   assign host_active = mode_q && !pwm_multi_out_active
      && (dir_q == 3'h7)
      && (acfg_q[3:0] >= PCFG_DIGITAL_MIN)
      && (acfg_q[3:0] <= PCFG_DIGITAL_MAX);

   // pin 0 read, pin 1 write, pin 2 select, all active low
   assign wr_low = host_active && !pin_s[2] && !pin_s[1];
   assign rd_low = host_active && !pin_s[2] && !pin_s[0];

   // output drivers ignore the analog setting
   assign port_e_oe = ~dir_q;
   assign port_e_out = out_lat_q;

   // ------------------------------------------------------------
   // host cycle tracker
   // ------------------------------------------------------------
   // a cycle runs to its end before the other kind can start
   always_comb
   begin
      state_d = state_q;
      case (state_q)
         ST_IDLE:
            if (wr_low)
               state_d = ST_WRITE;
            else if (rd_low)
               state_d = ST_READ;
         ST_WRITE:
            if (!wr_low)
               state_d = ST_IDLE;
         ST_READ:
            if (!rd_low)
               state_d = ST_IDLE;
         default:
            state_d = ST_IDLE;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         state_q <= ST_IDLE;
      else
         state_q <= state_d;
   end

   assign wr_end = (state_q == ST_WRITE) && !wr_low;
   assign rd_start = (state_q == ST_IDLE) && !wr_low && rd_low;
   assign rd_end = (state_q == ST_READ) && !rd_low;

   // pins follow the latch at once, even mid-read
   assign data_port_oe = (state_q == ST_READ);
   assign data_port_out = out_buf_q;

   // ------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------
   assign setup = psel && !penable;
   assign access = psel && penable;
   assign pready = 1'b1;
   assign prdata = prdata_q;
   assign pslverr = slverr_q;
   assign hit_known = (paddr == OFF_PIN_VALUES) || (paddr == OFF_OUT_LATCH)
      || (paddr == OFF_DIR_CTRL) || (paddr == OFF_ANALOG_CFG)
      || (paddr == OFF_DATA_PORT) || (paddr == OFF_HOST_STATUS);
   assign sw_wr_data = access && pwrite && (paddr == OFF_DATA_PORT);
   assign sw_rd_data = access && !pwrite && (paddr == OFF_DATA_PORT);
   assign sw_wr_dir = access && pwrite && (paddr == OFF_DIR_CTRL);
   assign sw_wr_stat = access && pwrite && (paddr == OFF_HOST_STATUS);

   // ------------------------------------------------------------
   // read data, captured in the setup cycle
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prdata_q <= 32'h0000_0000;
         slverr_q <= 1'b0;
      end
      else if (setup)
      begin
         slverr_q <= !hit_known;
         prdata_q <= 32'h0000_0000;
         case (paddr)
            OFF_PIN_VALUES:
               prdata_q[3:0] <= {pin3_q && !ext_reset_pin_enable,
                  pin_s & ~analog_en};
            OFF_OUT_LATCH:
               prdata_q[2:0] <= out_lat_q;
            OFF_DIR_CTRL:
               prdata_q[7:0] <= {in_full_q, out_full_q, overrun_q,
                  mode_q, 1'b0, dir_q};
            OFF_ANALOG_CFG:
               prdata_q[5:0] <= acfg_q;
            OFF_DATA_PORT:
               prdata_q[7:0] <= in_buf_q;
            OFF_HOST_STATUS:
               prdata_q[BIT_IRQ_FLAG] <= irq_q;
            default:
               prdata_q <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // software configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         dir_q <= DIR_RST;
         mode_q <= 1'b0;
         acfg_q <= ANALOG_CFG_RST;
         out_lat_q <= OUT_LATCH_RST;
      end
      else if (access && pwrite)
      begin
         if (paddr == OFF_DIR_CTRL)
         begin
            dir_q <= pwdata[2:0];
            mode_q <= pwdata[BIT_MODE_SEL];
         end
         if (paddr == OFF_ANALOG_CFG)
            acfg_q <= pwdata[5:0];
         // a pin register write lands in the output latch
         if ((paddr == OFF_OUT_LATCH) || (paddr == OFF_PIN_VALUES))
            out_lat_q <= pwdata[2:0];
      end
   end

   // ------------------------------------------------------------
   // data latches
   // ------------------------------------------------------------
   // host data must outlast its strobe: writes are seen late
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_buf_q <= DATA_RST;
      else if (wr_low)
         in_buf_q <= data_port_in;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_buf_q <= DATA_RST;
      else if (sw_wr_data)
         out_buf_q <= pwdata[7:0];
   end

   // ------------------------------------------------------------
   // flags; hardware events win over software accesses
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         in_full_q <= 1'b0;
      else if (wr_end)
         in_full_q <= 1'b1;
      else if (sw_rd_data)
         in_full_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         out_full_q <= 1'b0;
      else if (rd_start)
         out_full_q <= 1'b0;
      else if (sw_wr_data && (state_q != ST_READ))
         out_full_q <= 1'b1;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         overrun_q <= 1'b0;
      else if (wr_end && in_full_q)
         overrun_q <= 1'b1;
      else if (sw_wr_dir && !pwdata[BIT_OVERRUN])
         overrun_q <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         irq_q <= 1'b0;
      else if (wr_end || rd_end)
         irq_q <= 1'b1;
      else if (sw_wr_stat && pwdata[BIT_IRQ_FLAG])
         irq_q <= 1'b0;
   end

   // ------------------------------------------------------------
   // pin 3: input only, reset input or data bit
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pin3_q <= 1'b1;
         hv_q <= 1'b0;
         ext_rst_q <= 1'b0;
      end
      else
      begin
         pin3_q <= port_e_pin3;
         hv_q <= high_voltage_in;
         ext_rst_q <= ext_reset_pin_enable && !port_e_pin3;
      end
   end

   assign prog_entry_detect = hv_q;
   assign external_reset_req = ext_rst_q;

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_host_write_held;
      (host_active && !port_e_in[2] && !port_e_in[1])[*3];
   endsequence
   property p_sync_write_start;
      s_host_write_held |=> (state_q == ST_WRITE);
   endproperty
   a_sync_write_start: assert property (p_sync_write_start)
      else $error("write not seen after synchroniser delay");
   property p_write_end_flags;
      wr_end |=> in_full_q && irq_q;
   endproperty
   a_write_end_flags: assert property (p_write_end_flags)
      else $error("write end did not set input full and irq");
   property p_overrun;
      wr_end && in_full_q |=> overrun_q;
   endproperty
   a_overrun: assert property (p_overrun)
      else $error("second write did not set overrun");
   property p_read_start;
      rd_start |=> data_port_oe && !out_full_q
         && (data_port_out == $past(out_buf_q));
   endproperty
   a_read_start: assert property (p_read_start)
      else $error("read start did not drive latch or clear full");
   property p_write_in_read;
      data_port_oe && sw_wr_data |=>
         (data_port_out == $past(pwdata[7:0])) && !out_full_q;
   endproperty
   a_write_in_read: assert property (p_write_in_read)
      else $error("write during read mishandled");
   property p_read_end;
      rd_end |=> !data_port_oe && irq_q;
   endproperty
   a_read_end: assert property (p_read_end)
      else $error("read end did not release pins or set irq");
   property p_mode_gate;
      !host_active |=> !data_port_oe;
   endproperty
   a_mode_gate: assert property (p_mode_gate)
      else $error("data pins driven outside host mode");
   property p_dir_drive;
      sw_wr_dir && !pwdata[0] |=> port_e_oe[0]
         && (port_e_out[0] == out_lat_q[0]);
   endproperty
   a_dir_drive: assert property (p_dir_drive)
      else $error("cleared direction bit did not drive pin");
   property p_reset_pin;
      !ext_reset_pin_enable ##1 !ext_reset_pin_enable
         |-> !external_reset_req;
   endproperty
   a_reset_pin: assert property (p_reset_pin)
      else $error("reset request while reset pin disabled");
   property p_zero_bits;
      access && !pwrite && (paddr == OFF_PIN_VALUES)
         |-> (prdata[31:4] == 28'h0000000);
   endproperty
   a_zero_bits: assert property (p_zero_bits)
      else $error("unimplemented bits read nonzero");

endmodule

// >>> common/host_port_pkg.sv
/*
 * constants, register map and state type of the parallel host port
 * and its port e pin logic.
 * assumes a 32-bit apb bus with byte addresses on an 8-bit paddr.
 */
package host_port_pkg;

   // ------------------------------------------------------------
   // register map, byte addresses
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam logic [7:0] OFF_PIN_VALUES = 8'h00;
   localparam logic [7:0] OFF_OUT_LATCH = 8'h04;
   localparam logic [7:0] OFF_DIR_CTRL = 8'h08;
   localparam logic [7:0] OFF_ANALOG_CFG = 8'h0C;
   localparam logic [7:0] OFF_DATA_PORT = 8'h10;
   localparam logic [7:0] OFF_HOST_STATUS = 8'h14;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int BIT_INPUT_FULL = 7;
   localparam int BIT_OUTPUT_FULL = 6;
   localparam int BIT_OVERRUN = 5;
   localparam int BIT_MODE_SEL = 4;
   localparam int BIT_IRQ_FLAG = 0;

   // ------------------------------------------------------------
   // reset values and thresholds
   // ------------------------------------------------------------
   localparam logic [2:0] DIR_RST = 3'h7;
   localparam logic [2:0] OUT_LATCH_RST = 3'h0;
   localparam logic [5:0] ANALOG_CFG_RST = 6'h00;
   localparam logic [7:0] DATA_RST = 8'h00;
   localparam logic [3:0] PCFG_DIGITAL_MIN = 4'hA;
   localparam logic [3:0] PCFG_DIGITAL_MAX = 4'hF;

   // ------------------------------------------------------------
   // host cycle tracker
   // ------------------------------------------------------------
   typedef enum logic [2:0]
   {
      ST_IDLE = 3'b001,
      ST_WRITE = 3'b010,
      ST_READ = 3'b100
   } host_state_type;

endpackage

// >>> design/sync_bank.sv
/*
 * bank of two-stage synchronisers, one per bit.
 * assumes inputs may change at any time relative to pclk.
 */
module sync_bank #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '1
)
(
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_q;

   // first stage is read only by the second stage
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         meta_q <= RST_VAL;
         q <= RST_VAL;
      end
      else
      begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule

// >>> tb/host_model.sv
/*
 * model of the external processor on the host slave port.
 * assumes the bench calls wr and rd one at a time, on pclk.
 */
module host_model
(
   // clock
   input wire logic pclk,
   // data port pins
   input wire logic [7:0] data_port_out,
   input wire logic data_port_oe,
   output logic [7:0] data_port_in,
   // strobes: bit0 read_n, bit1 write_n, bit2 select_n
   output logic [2:0] port_e_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // host cycles
   // ------------------------------------------------------------
   logic [7:0] dq = 8'h00;
   logic [2:0] p = 3'h7;
   assign data_port_in = dq;
   assign port_e_in = p;
   // write: select and write low for n cycles, data held after rise
   task automatic wr(input logic [7:0] b, input int n);
      @(posedge pclk);
      p <= 3'h1;
      dq <= b;
      repeat (n) @(posedge pclk);
      p <= 3'h7;
      repeat (4) @(posedge pclk);
      // a released bus must not keep the byte it carried
      dq <= ~b;
      repeat (2) @(posedge pclk);
   endtask
   // read: waits (bounded) for the pins to be driven, holds n cycles
   task automatic rd(output logic [7:0] b, input int n);
      int k;
      @(posedge pclk);
      p <= 3'h2;
      for (k = 0; k < 20 && data_port_oe !== 1'b1; k++) @(posedge pclk);
      repeat (n) @(posedge pclk);
      // undriven pins must not pass for the latch contents
      b = (data_port_oe === 1'b1) ? data_port_out : ~data_port_out;
      p <= 3'h7;
      repeat (5) @(posedge pclk);
   endtask
endmodule

// >>> tb/host_slave_port_tb.sv
/*
 * self-checking bench of the host slave port: apb registers, host
 * cycles and port e pins.
 * assumes pready answers within the watchdog span.
 */
module host_slave_port_tb;
   import host_port_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   // ------------------------------------------------------------
   // signals and instances
   // ------------------------------------------------------------
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, dpoe, prog, extreq;
   logic [7:0] dpi, dpo, b1, b2, hb;
   logic [2:0] pei, peo, peoe, asel;
   logic pin3 = 1'b0;
   logic hv = 1'b0;
   logic ext_en = 1'b0;
   logic pwm = 1'b0;
   logic [31:0] seed = 32'd31203;
   logic [31:0] r;
   logic [16:0] bad [4] = '{17'h00A07, 17'h10A17, 17'h00917, 17'h00A16};
   logic [32:0] exq [$];
   int mismatches = 0;
   int cmp_count = 0;
   always #5 pclk = ~pclk;
   host_slave_port i_host_slave_port (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .data_port_in(dpi), .data_port_out(dpo),
      .data_port_oe(dpoe), .port_e_in(pei), .port_e_out(peo),
      .port_e_oe(peoe), .port_e_pin3(pin3), .high_voltage_in(hv),
      .prog_entry_detect(prog), .external_reset_req(extreq),
      .ext_reset_pin_enable(ext_en), .pwm_multi_out_active(pwm),
      .analog_pin_sel(asel));
   host_model i_host_model (.pclk(pclk), .data_port_out(dpo),
      .data_port_oe(dpoe), .data_port_in(dpi), .port_e_in(pei));
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("unexpected at %0t: got %h want %h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask
   // expected {pslverr, prdata} is noted before the read goes out
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exq.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task automatic cfg(input logic [7:0] ac, input logic [7:0] dc);
      wr(OFF_ANALOG_CFG, {24'h0, ac});
      wr(OFF_DIR_CTRL, {24'h0, dc});
   endtask
   task automatic close_out();
      repeat (4) @(posedge pclk);
      if (exq.size() != 0)
         mismatches++;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   always @(posedge pclk)
      if (psel && penable && pready === 1'b1 && !pwrite)
         chk({pslverr, prdata}, exq.pop_front());
   initial
   begin
      #200000;
      mismatches++;
      close_out();
   end
   // ------------------------------------------------------------
   // tests
   // ------------------------------------------------------------
   initial
   begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      chk(33'(asel), 33'h7);
      rd(OFF_DIR_CTRL, 33'h07);
      rd(OFF_ANALOG_CFG, 33'h0);
      rd(OFF_OUT_LATCH, 33'h0);
      rd(OFF_HOST_STATUS, 33'h0);
      rd(8'h18, {1'b1, 32'h0});
      $display("test reset done");
      for (int i = 0; i < 4; i++)
      begin
         pwm <= bad[i][16];
         cfg(bad[i][15:8], bad[i][7:0]);
         i_host_model.wr(8'(xs()), 4);
         rd(OFF_HOST_STATUS, 33'h0);
         rd(OFF_DIR_CTRL, {25'h0, bad[i][7:0]});
      end
      $display("test refusal done");
      pwm <= 1'b0;
      cfg(8'h0F, 8'h17);
      b1 = 8'(xs());
      i_host_model.wr(b1, 3);
      rd(OFF_HOST_STATUS, 33'h1);
      rd(OFF_DIR_CTRL, 33'h97);
      b2 = 8'(xs());
      i_host_model.wr(b2, 6);
      rd(OFF_DIR_CTRL, 33'hB7);
      rd(OFF_DATA_PORT, {25'h0, b2});
      rd(OFF_DIR_CTRL, 33'h37);
      wr(OFF_DIR_CTRL, 32'h17);
      rd(OFF_DIR_CTRL, 33'h17);
      wr(OFF_HOST_STATUS, 32'h1);
      rd(OFF_HOST_STATUS, 33'h0);
      $display("test host write done");
      cfg(8'h0A, 8'h17);
      wr(OFF_DATA_PORT, {24'h0, b1});
      rd(OFF_DIR_CTRL, 33'h57);
      i_host_model.rd(hb, 3);
      chk(33'(hb), 33'(b1));
      chk(33'(dpoe), 33'h0);
      rd(OFF_DIR_CTRL, 33'h17);
      rd(OFF_HOST_STATUS, 33'h1);
      wr(OFF_HOST_STATUS, 32'h1);
      fork
         i_host_model.rd(hb, 12);
         begin
            repeat (6) @(posedge pclk);
            wr(OFF_DATA_PORT, {24'h0, b2});
         end
      join
      chk(33'(hb), 33'(b2));
      rd(OFF_DIR_CTRL, 33'h17);
      $display("test host read done");
      cfg(8'h0F, 8'h00);
      wr(OFF_OUT_LATCH, 32'hFD);
      @(posedge pclk);
      chk(33'(peo), 33'h5);
      chk(33'(peoe), 33'h7);
      rd(OFF_OUT_LATCH, 33'h5);
      wr(OFF_PIN_VALUES, 32'hFA);
      wr(8'h18, 32'hFF);
      rd(OFF_OUT_LATCH, 33'h2);
      for (int i = 0; i < 3; i++)
      begin
         r = xs();
         i_host_model.p <= r[2:0];
         pin3 <= r[3];
         cfg(8'h0F, 8'h07);
         rd(OFF_PIN_VALUES, {29'h0, r[3:0]});
         cfg(8'h00, 8'h07);
         rd(OFF_PIN_VALUES, {29'h0, r[3], 3'h0});
         chk(33'(asel), 33'h7);
      end
      ext_en <= 1'b1;
      pin3 <= 1'b0;
      hv <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(33'(extreq), 33'h1);
      chk(33'(prog), 33'h1);
      pin3 <= 1'b1;
      rd(OFF_PIN_VALUES, 33'h0);
      i_host_model.p <= 3'h7;
      $display("test port e done");
      close_out();
   end
endmodule
